// [core/mpr_regs.vh]
`ifndef MPR_REGS_VH
`define MPR_REGS_VH

// block base on the private peripheral bus
`define MPR_BASE 32'hE000_ED90
// one past the last alias word
`define MPR_SPAN 32'h0000_002C

// word offsets from the block base
`define MPR_OFF_CAP 8'h00
`define MPR_OFF_CTRL 8'h04
`define MPR_OFF_RSEL 8'h08
`define MPR_OFF_RBASE 8'h0C
`define MPR_OFF_RATTR 8'h10

// capability register
`define MPR_CAP_RESET 32'h0000_0800

// base register fields
`define MPR_BASE_VALID_BIT 4
`define MPR_BASE_REGION_MSB 3
`define MPR_BASE_ADDR_LSB 5

// attribute/size register fields
`define MPR_ATTR_WMASK 32'h173F_FF3F
`define MPR_ATTR_RESET 32'h0000_0000
`define MPR_ATTR_EN_BIT 0
`define MPR_ATTR_SIZE_MSB 5
`define MPR_ATTR_SIZE_LSB 1
`define MPR_ATTR_SUBDIS_MSB 15
`define MPR_ATTR_SUBDIS_LSB 8

// region-select reset
`define MPR_RSEL_RESET 8'h00

// access size codes on the bus
`define MPR_SZ_BYTE 2'h0
`define MPR_SZ_HALF 2'h1
`define MPR_SZ_WORD 2'h2

// smallest log2 size that carries subregions (256 bytes)
`define MPR_SUB_MIN_LOG2 6'h08
// log2 size from which a region covers the whole map
`define MPR_WHOLE_LOG2 6'h20

`endif

// [core/mpr_region_match.v]
`timescale 1ns/1ps
`include "mpr_regs.vh"

module mpr_region_match (
    input wire [26:0] base,
    input wire [31:0] attr,
    input wire [31:0] addr,
    output wire hit
);

    wire [5:0] log2_size;
    wire whole_map;
    wire [31:0] hi_mask;
    wire in_range;
    wire [5:0] sub_shift;
    wire [31:0] shifted;
    wire [2:0] sub_idx;
    wire has_sub;
    wire [7:0] subdis;

    assign log2_size = {1'b0, attr[`MPR_ATTR_SIZE_MSB:`MPR_ATTR_SIZE_LSB]} + 6'h01;
    assign whole_map = (log2_size >= `MPR_WHOLE_LOG2);
    assign hi_mask = 32'hFFFF_FFFF << log2_size;
    assign in_range = whole_map | (((addr ^ {base, 5'h00}) & hi_mask) == 32'h0000_0000);

    assign sub_shift = log2_size - 6'h03;
    assign shifted = addr >> sub_shift;
    assign sub_idx = shifted[2:0];
    assign has_sub = (log2_size >= `MPR_SUB_MIN_LOG2);
    assign subdis = attr[`MPR_ATTR_SUBDIS_MSB:`MPR_ATTR_SUBDIS_LSB];

    assign hit = attr[`MPR_ATTR_EN_BIT] & in_range & ~(has_sub & subdis[sub_idx]);

endmodule // mpr_region_match

// [core/mpr_top.v]
`timescale 1ns/1ps
`include "mpr_regs.vh"

// Behaviour
// - aliases let one burst program four regions
// - select and base at fixed addresses
// - word only, except attribute byte/halfword
// - consecutive writes each act individually
// - valid base write also loads select
// - large regions split into eight subregions
// - subregion bit zero is lowest address
// - disabled subregion falls to other regions
// - register accesses complete in program order
// - new settings apply at next access
// - dma transfers bypass region checks
// - capability register reads 0x0000_0800
// - instruction region count reads zero
// - data region count is eight
// - unified map flag reads zero
module mpr_top #(
    parameter NUM_REGIONS = 8
) (
    input wire clk,
    input wire resetn,
    input wire ppb_sel,
    input wire ppb_write,
    input wire [31:0] ppb_addr,
    input wire [1:0] ppb_size,
    input wire [31:0] ppb_wdata,
    output reg [31:0] ppb_rdata,
    output reg ppb_ready,
    output reg ppb_err,
    input wire chk_valid,
    input wire [31:0] chk_addr,
    input wire chk_is_dma,
    output reg chk_done,
    output reg chk_hit,
    output reg chk_fault,
    output reg [2:0] chk_region,
    output reg [15:0] chk_attr
);

    ////////////////////////////////////////////////////////////////////////
    // state

    reg [7:0] rsel_q;
    reg [26:0] base_q [0:NUM_REGIONS-1];
    reg [31:0] attr_q [0:NUM_REGIONS-1];
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire [31:0] off_full;
    wire in_block;
    wire [7:0] off;
    wire [7:0] word_off;
    wire is_cap;
    wire is_ctrl;
    wire is_rsel;
    wire is_base;
    wire is_attr;
    wire word_ok;
    wire attr_ok;
    wire acc_ok;
    wire [2:0] cur;

    assign off_full = ppb_addr - `MPR_BASE;
    assign in_block = (off_full < `MPR_SPAN);
    assign off = off_full[7:0];
    assign word_off = {off[7:2], 2'b00};
    assign is_cap = in_block & (word_off == `MPR_OFF_CAP);
    assign is_ctrl = in_block & (word_off == `MPR_OFF_CTRL);
    assign is_rsel = in_block & (word_off == `MPR_OFF_RSEL);
    assign is_base = in_block & (word_off >= `MPR_OFF_RBASE) & word_off[2];
    assign is_attr = in_block & (word_off >= `MPR_OFF_RATTR) & ~word_off[2];

    assign word_ok = (ppb_size == `MPR_SZ_WORD) & (off[1:0] == 2'b00);
    assign attr_ok = word_ok | (ppb_size == `MPR_SZ_BYTE) |
                     ((ppb_size == `MPR_SZ_HALF) & ~off[0]);
    assign acc_ok = in_block & (is_attr ? attr_ok : word_ok);
    assign cur = rsel_q[2:0];

    ////////////////////////////////////////////////////////////////////////
    // byte lanes for attribute writes

    reg [3:0] be;
    reg [31:0] lane_mask;

    always @* begin
        case (ppb_size)
            `MPR_SZ_WORD: be = 4'hF;
            `MPR_SZ_HALF: be = off[1] ? 4'hC : 4'h3;
            default: be = 4'h1 << off[1:0];
        endcase
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    wire do_wr;
    wire base_valid;
    wire [2:0] base_tgt;
    wire [31:0] attr_new;

    assign do_wr = ppb_sel & ppb_write & acc_ok;
    assign base_valid = ppb_wdata[`MPR_BASE_VALID_BIT];
    assign base_tgt = base_valid ? ppb_wdata[2:0] : cur;
    assign attr_new = ((attr_q[cur] & ~lane_mask) | (ppb_wdata & lane_mask)) &
                      `MPR_ATTR_WMASK;

    // one access per cycle, in order
    // each burst beat stored as single write
    always @(posedge clk) begin
        if (!resetn) begin
            rsel_q <= `MPR_RSEL_RESET;
            for (i = 0; i < NUM_REGIONS; i = i + 1) begin
                base_q[i] <= 27'h000_0000;
                attr_q[i] <= `MPR_ATTR_RESET;
            end
        end else if (do_wr) begin
            if (is_rsel) begin
                rsel_q <= ppb_wdata[7:0];
            end
            if (is_base) begin
                if (base_valid) begin
                    rsel_q <= {4'h0, ppb_wdata[`MPR_BASE_REGION_MSB:0]};
                end
                base_q[base_tgt] <= ppb_wdata[31:`MPR_BASE_ADDR_LSB];
            end
            if (is_attr) begin
                attr_q[cur] <= attr_new;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads and bus answer

    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h0000_0000;
        if (is_cap) begin
            rd_d = `MPR_CAP_RESET;
        end else if (is_rsel) begin
            rd_d = {24'h00_0000, rsel_q};
        end else if (is_base) begin
            rd_d = {base_q[cur], 1'b0, rsel_q[`MPR_BASE_REGION_MSB:0]};
        end else if (is_attr) begin
            rd_d = attr_q[cur];
        end else if (is_ctrl) begin
            rd_d = 32'h0000_0000;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            ppb_rdata <= 32'h0000_0000;
            ppb_ready <= 1'b0;
            ppb_err <= 1'b0;
        end else begin
            ppb_ready <= ppb_sel;
            ppb_err <= ppb_sel & ~acc_ok;
            if (ppb_sel & ~ppb_write & acc_ok) begin
                ppb_rdata <= rd_d;
            end else begin
                ppb_rdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // region matching

    wire [NUM_REGIONS-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g = g + 1) begin : g_reg
            mpr_region_match u_match (
                .base(base_q[g]),
                .attr(attr_q[g]),
                .addr(chk_addr),
                .hit(hit[g])
            );
        end
    endgenerate

    // highest numbered enabled hit wins
    reg [2:0] win_idx;
    reg win_any;
    integer k;

    always @* begin
        win_idx = 3'h0;
        win_any = 1'b0;
        for (k = 0; k < NUM_REGIONS; k = k + 1) begin
            if (hit[k]) begin
                win_idx = k[2:0];
                win_any = 1'b1;
            end
        end
    end

    wire [31:0] win_attr;

    assign win_attr = attr_q[win_idx];

    // checks always use the live settings
    always @(posedge clk) begin
        if (!resetn) begin
            chk_done <= 1'b0;
            chk_hit <= 1'b0;
            chk_fault <= 1'b0;
            chk_region <= 3'h0;
            chk_attr <= 16'h0000;
        end else begin
            chk_done <= chk_valid;
            if (chk_valid & chk_is_dma) begin
                chk_hit <= 1'b0;
                chk_fault <= 1'b0;
                chk_region <= 3'h0;
                chk_attr <= 16'h0000;
            end else if (chk_valid) begin
                chk_hit <= win_any;
                chk_fault <= ~win_any;
                chk_region <= win_idx;
                chk_attr <= win_any ? win_attr[31:16] : 16'h0000;
            end else begin
                chk_hit <= 1'b0;
                chk_fault <= 1'b0;
                chk_region <= 3'h0;
                chk_attr <= 16'h0000;
            end
        end
    end

endmodule // mpr_top

// [tb/mpr_top_properties.sv]
`timescale 1ns/1ps
module mpr_top_properties #(
    parameter NUM_REGIONS = 8
) (
    input wire clk, resetn, ppb_sel, ppb_write, ppb_ready, ppb_err,
    input wire [31:0] ppb_addr, ppb_wdata, ppb_rdata,
    input wire [1:0] ppb_size,
    input wire chk_valid, chk_is_dma, chk_done, chk_hit, chk_fault,
    input wire [31:0] chk_addr,
    input wire [2:0] chk_region,
    input wire [15:0] chk_attr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd_w = ppb_sel && !ppb_write && ppb_size == 2'h2;
    sequence base_pack_s;
        ppb_sel && ppb_write && ppb_addr == 32'hE000_ED9C && ppb_size == 2'h2 && ppb_wdata[4];
    endsequence
    sequence sel_read_s;
        rd_w && ppb_addr == 32'hE000_ED98;
    endsequence
    answer_next_a: assert property (ppb_sel |=> ppb_ready)
        else $error("bus answer missing");
    cap_read_a: assert property (rd_w && ppb_addr == 32'hE000_ED90 |=>
        ppb_rdata == 32'h0000_0800 && !ppb_err) else $error("capability read wrong");
    word_only_a: assert property (ppb_sel && ppb_addr == 32'hE000_ED98
        && ppb_size != 2'h2 |=> ppb_err) else $error("narrow select access taken");
    half_odd_a: assert property (ppb_sel && ppb_addr == 32'hE000_EDA1
        && ppb_size == 2'h1 |=> ppb_err) else $error("odd halfword taken");
    err_pair_a: assert property (ppb_err |-> ppb_ready)
        else $error("error without answer");
    dma_pass_a: assert property (chk_valid && chk_is_dma |=>
        chk_done && !chk_hit && !chk_fault) else $error("dma access checked");
    hit_fault_a: assert property (chk_valid && !chk_is_dma |=>
        chk_done && (chk_hit ^ chk_fault)) else $error("hit and fault disagree");
    pack_select_a: assert property (base_pack_s ##3 sel_read_s |=>
        ppb_rdata == {28'h000_0000, $past(ppb_wdata[3:0], 4)}) else $error("select not loaded");
endmodule // mpr_top_properties
bind mpr_top mpr_top_properties #(.NUM_REGIONS(NUM_REGIONS)) chk_u (.*);

// [tb/mpr_core_model.sv]
`timescale 1ns/1ps
module mpr_core_model (
    input wire clk,
    input wire ppb_ready,
    input wire ppb_err,
    input wire [31:0] ppb_rdata,
    output reg ppb_sel = 1'b0,
    output reg ppb_write = 1'b0,
    output reg [31:0] ppb_addr = 32'h0000_0000,
    output reg [31:0] ppb_wdata = 32'h0000_0000,
    output reg [1:0] ppb_size = 2'h0
);
    reg [31:0] rd_q = 32'h0000_0000;
    reg err_q = 1'b0;
    reg ok_q = 1'b0;
    integer i;
    task xfer(input w, input [31:0] a, input [1:0] s, input [31:0] d);
        begin
            @(posedge clk);
            ppb_sel <= 1'b1;
            ppb_write <= w;
            ppb_addr <= a;
            ppb_size <= s;
            ppb_wdata <= d;
            @(posedge clk);
            ppb_sel <= 1'b0;
            ppb_addr <= ~a;
            ppb_wdata <= ~d;
            ok_q = 1'b0;
            for (i = 0; i < 4 && !ok_q; i = i + 1) begin
                @(posedge clk);
                ok_q = ppb_ready;
                rd_q = ppb_rdata;
                err_q = ppb_err;
            end
        end
    endtask
    // select, base, attribute back to back
    task burst3(input [31:0] a, input [31:0] d0, input [31:0] d1, input [31:0] d2);
        begin
            @(posedge clk);
            ppb_sel <= 1'b1;
            ppb_write <= 1'b1;
            ppb_size <= 2'h2;
            ppb_addr <= a;
            ppb_wdata <= d0;
            @(posedge clk);
            ppb_addr <= a + 32'h0000_0004;
            ppb_wdata <= d1;
            @(posedge clk);
            ok_q = ppb_ready;
            err_q = ppb_err;
            ppb_addr <= a + 32'h0000_0008;
            ppb_wdata <= d2;
            @(posedge clk);
            ok_q = ok_q & ppb_ready;
            err_q = err_q | ppb_err;
            ppb_sel <= 1'b0;
            ppb_addr <= ~a;
            @(posedge clk);
            ok_q = ok_q & ppb_ready;
            err_q = err_q | ppb_err;
        end
    endtask
endmodule // mpr_core_model

// [tb/mpr_top_tb_top.sv]
`timescale 1ns/1ps
module mpr_top_tb_top;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg chk_valid = 1'b0;
    reg chk_is_dma = 1'b0;
    reg [31:0] chk_addr = 32'h0000_0000;
    wire ppb_sel, ppb_write, ppb_ready, ppb_err, chk_done, chk_hit, chk_fault;
    wire [31:0] ppb_addr, ppb_wdata, ppb_rdata;
    wire [1:0] ppb_size;
    wire [2:0] chk_region;
    wire [15:0] chk_attr;
    integer n_fail = 0;
    integer check_count = 0;
    integer k;
    reg [31:0] w_q [0:3];
    always #10 clk = ~clk;
    mpr_top #(.NUM_REGIONS(8)) dut_u (.*);
    mpr_core_model core_u (.*);
    function [15:0] exp_attr(input [31:0] w);
        exp_attr = w[31:16] & 16'h173F;
    endfunction
    task stop_test;
        begin
            if (n_fail == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task bus(input w, input [31:0] a, input [1:0] s, input [31:0] d);
        begin
            core_u.xfer(w, a, s, d);
            if (!core_u.ok_q) begin
                n_fail = n_fail + 1;
                stop_test;
            end
        end
    endtask
    task chk(input [31:0] a, input dma, input [4:0] hfr, input [15:0] at);
        begin
            @(posedge clk);
            chk_valid <= 1'b1;
            chk_addr <= a;
            chk_is_dma <= dma;
            @(posedge clk);
            chk_valid <= 1'b0;
            chk_addr <= ~a;
            @(posedge clk);
            cmp({10'h000, chk_done, chk_hit, chk_fault, chk_region, chk_attr},
                {10'h000, 1'b1, hfr, at});
        end
    endtask
    initial begin
        w_q[0] = $urandom(32'h2b34_e6d9);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        bus(0, 32'hE000_ED90, 2'h2, 32'h0000_0000);
        cmp(core_u.rd_q, 32'h0000_0800);
        bus(1, 32'hE000_ED90, 2'h2, $urandom);
        bus(0, 32'hE000_ED90, 2'h2, 32'h0000_0000);
        cmp(core_u.rd_q, 32'h0000_0800);
        chk(32'h2000_0100, 0, 5'h08, 16'h0000);
        chk(32'h2000_0100, 1, 5'h00, 16'h0000);
        bus(1, 32'hE000_ED98, 2'h2, 32'h0000_0002);
        bus(1, 32'hE000_ED9C, 2'h2, 32'h2000_0000);
        bus(1, 32'hE000_EDA0, 2'h1, 32'h0000_0017);
        bus(1, 32'hE000_EDA2, 2'h1, 32'h0306_0000);
        chk(32'h2000_0100, 0, 5'h12, 16'h0306);
        bus(1, 32'hE000_ED98, 2'h1, 32'h0000_0007);
        cmp({31'h0000_0000, core_u.err_q}, 32'h0000_0001);
        bus(1, 32'hE000_EDA1, 2'h1, 32'h0000_0000);
        cmp({31'h0000_0000, core_u.err_q}, 32'h0000_0001);
        bus(0, 32'hE000_EDBC, 2'h2, 32'h0000_0000);
        cmp({31'h0000_0000, core_u.err_q}, 32'h0000_0001);
        bus(0, 32'hE000_ED98, 2'h2, 32'h0000_0000);
        cmp(core_u.rd_q, 32'h0000_0002);
        bus(1, 32'hE000_ED9C, 2'h2, 32'h2000_0015);
        bus(0, 32'hE000_ED98, 2'h2, 32'h0000_0000);
        cmp(core_u.rd_q, 32'h0000_0005);
        bus(1, 32'hE000_EDA0, 2'h2, 32'h0100_0117);
        chk(32'h2000_0100, 0, 5'h12, 16'h0306);
        chk(32'h2000_0200, 0, 5'h15, 16'h0100);
        chk(32'h2000_0F00, 0, 5'h15, 16'h0100);
        bus(1, 32'hE000_EDA0, 2'h1, 32'h0000_0116);
        chk(32'h2000_0200, 0, 5'h12, 16'h0306);
        core_u.burst3(32'hE000_ED98, 32'h0000_0003, 32'h3000_0000, 32'h0306_000D);
        cmp({30'h0000_0000, core_u.ok_q, core_u.err_q}, 32'h0000_0002);
        chk(32'h3000_0040, 0, 5'h13, 16'h0306);
        chk(32'h3000_0080, 0, 5'h08, 16'h0000);
        for (k = 0; k < 4; k = k + 1) begin
            w_q[k] = ($urandom << 16) | 32'h0000_001F;
            bus(1, 32'hE000_ED9C + 8 * k, 2'h2, 32'h6000_0014 + (k << 20) + k);
            bus(1, 32'hE000_EDA0 + 8 * k, 2'h2, w_q[k]);
        end
        for (k = 0; k < 4; k = k + 1)
            chk(32'h6000_0000 + (k << 20) + $urandom % 65536, 0, 5'h14 + k[4:0],
                exp_attr(w_q[k]));
        stop_test;
    end
endmodule // mpr_top_tb_top
